// >>> logic/uarx_receiver.sv
// Asynchronous receiver front end: oversampled start detection, majority voting,
// multi-processor filter and a two-entry receive buffer.
// Assumes the serial pin is asynchronous to clk before the two-flop stage and that
// configuration changes only while the receiver is disabled.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Turning the receiver off empties the receive buffer completely.
// - Sample at sixteen times bit rate, or eight in double speed.
// - A falling edge on idle line starts detection, first low is sample one.
// - Start qualified by votes on samples 8-10, or 4-6 in double speed.
// - Two or more high qualifying samples reject the start as noise.
// - Bit phase resynchronises on every accepted start bit.
// - Recovery counts sixteen or eight states per bit, numbering samples.
// - Each bit is the majority of its three centre samples.
// - Recovery runs through the first stop bit; later stop bits ignored.
// - A stop bit voted zero sets the frame error stored with the frame.
// - Next start edge accepted right after the last stop vote sample, one sample later in double speed.
// - With the filter on, non-address frames are dropped before buffering.
// - The filter only affects received frames, never a transmitter.
// - Type bit is the first stop bit, or ninth bit in nine-bit frames.
// - Type bit one means address frame, zero means data frame.
// - A slave with filter off receives data frames normally.
// - Complete flag is one while unread characters remain in the buffer.
// - Size setting seven selects nine bits, ninth bit stored per frame.
module uarx_receiver
	import uarx_pkg::*;
#(
	parameter int unsigned DEPTH = UARX_FIFO_DEPTH
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic serial_rx_pin,
	input wire uarx_cfg_t cfg,
	input wire logic parity_odd,
	input wire logic rd_strobe,
	output logic [7:0] rx_data_buffer,
	output logic rx_ninth_bit,
	output logic frame_error_flag,
	output logic rx_complete_flag,
	output logic [1:0] rx_count
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	function automatic logic vote3(input logic [2:0] s);
		vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	function automatic logic [3:0] data_bits(input logic [2:0] size);
		data_bits = (size == UARX_SIZE_NINE) ? 4'h9 : {1'b0, size} + 4'h5;
	endfunction

	logic sync1_reg;
	logic sync2_reg;
	logic line_reg;
	logic line_prev_reg;
	logic [15:0] div_reg;
	logic tick_reg;
	uarx_state_t state_reg;
	logic [4:0] sample_reg;
	logic [2:0] vote_reg;
	logic [3:0] bit_reg;
	logic [8:0] shift_reg;
	logic push_reg;
	uarx_entry_t push_entry_reg;
	uarx_entry_t mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [1:0] count_reg;

	logic [4:0] spb;
	logic [4:0] vote_first;
	logic [4:0] vote_last;
	logic vote_now;
	logic bit_done;
	logic voted;
	logic [3:0] nbits;
	logic stop_phase_end;
	logic fall_seen;
	logic frame_type;
	logic do_wr;
	logic do_rd;
	assign spb = cfg.double_speed_select ? UARX_SPB_DOUBLE : UARX_SPB_NORMAL;
	assign vote_first = cfg.double_speed_select ? UARX_VOTE_FIRST_DOUBLE : UARX_VOTE_FIRST_NORMAL;
	assign vote_last = vote_first + 5'h02;
	assign vote_now = tick_reg && sample_reg >= vote_first && sample_reg <= vote_last;
	assign bit_done = tick_reg && sample_reg == spb;
	assign voted = vote3({vote_reg[1:0], line_reg});
	assign nbits = data_bits(cfg.char_size_select);
	// Normal speed frees the line right after the last stop vote; double speed one sample later.
	assign stop_phase_end = tick_reg && sample_reg == (cfg.double_speed_select ? vote_last + 5'h01 : vote_last);
	// A line held low after a bad stop bit must not look like a new start, so a real edge is required.
	assign fall_seen = line_prev_reg && !line_reg;
	assign frame_type = (nbits == 4'h9) ? shift_reg[8] : voted;
	assign do_wr = push_reg && count_reg < 2'(DEPTH);
	assign do_rd = rd_strobe && count_reg != 2'h0;

	// Synchroniser: the first stage feeds only the second.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end
		else if (clk_en)
		begin
			sync1_reg <= serial_rx_pin;
			sync2_reg <= sync1_reg;
		end
	end

	// Baud sample tick; the divider restarts when the receiver is off.
	// The previous sample is kept so that idle detection sees transitions, not levels.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg <= UARX_DIV_RESET;
			tick_reg <= 1'b0;
			line_reg <= 1'b1;
			line_prev_reg <= 1'b1;
		end
		else if (clk_en)
		begin
			tick_reg <= 1'b0;
			if (!cfg.receiver_enable)
				div_reg <= cfg.baud_divider;
			else if (div_reg == 16'h0000)
			begin
				div_reg <= cfg.baud_divider;
				tick_reg <= 1'b1;
				line_prev_reg <= line_reg;
				line_reg <= sync2_reg;
			end
			else
				div_reg <= div_reg - 16'h0001;
		end
	end

	// Frame recovery state machine.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= UARX_IDLE;
			sample_reg <= 5'h00;
			vote_reg <= 3'h0;
			bit_reg <= 4'h0;
			shift_reg <= 9'h000;
			push_reg <= 1'b0;
			push_entry_reg <= '0;
		end
		else if (clk_en)
		begin
			push_reg <= 1'b0;
			if (!cfg.receiver_enable)
			begin
				state_reg <= UARX_IDLE;
				sample_reg <= 5'h00;
			end
			else if (tick_reg)
			begin
				if (vote_now)
					vote_reg <= {vote_reg[1:0], line_reg};
				sample_reg <= (sample_reg == spb) ? 5'h01 : sample_reg + 5'h01;
				case (state_reg)
					UARX_IDLE:
					begin
						// Each accepted edge is sample one, so the phase counter restarts at two.
						sample_reg <= 5'h02;
						if (fall_seen)
							state_reg <= UARX_START;
						else
							sample_reg <= 5'h01;
					end
					UARX_START:
					begin
						if (sample_reg == vote_last && voted)
							state_reg <= UARX_IDLE;
						else if (bit_done)
						begin
							state_reg <= UARX_DATA;
							bit_reg <= 4'h0;
						end
					end
					UARX_DATA:
					begin
						if (sample_reg == vote_last)
							shift_reg <= {voted, shift_reg[8:1]};
						if (bit_done)
						begin
							bit_reg <= bit_reg + 4'h1;
							if (bit_reg == nbits - 4'h1)
								state_reg <= cfg.parity_enable ? UARX_PARITY : UARX_STOP;
						end
					end
					UARX_PARITY:
					begin
						// The parity bit is only timed to keep framing; it is never checked.
						if (bit_done)
							state_reg <= UARX_STOP;
					end
					UARX_STOP:
					begin
						if (sample_reg == vote_last)
						begin
							push_entry_reg.data <= 8'(shift_reg >> (4'h9 - nbits));
							push_entry_reg.ninth <= (nbits == 4'h9) ? shift_reg[8] : 1'b0;
							push_entry_reg.frame_err <= !voted;
							// The filter only gates what is buffered; nothing here reaches a transmitter.
							push_reg <= !cfg.multiproc_filter_enable || frame_type;
						end
						if (stop_phase_end)
						begin
							state_reg <= UARX_IDLE;
							sample_reg <= 5'h01;
						end
					end
					default:
						state_reg <= UARX_IDLE;
				endcase
			end
		end
	end

	// Receive buffer: two entries in flip-flops, flushed on disable.
	// A full buffer drops the new frame so that the unread head is never overwritten.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= 2'h0;
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '0;
		end
		else if (clk_en)
		begin
			if (!cfg.receiver_enable)
			begin
				wr_ptr_reg <= '0;
				rd_ptr_reg <= '0;
				count_reg <= 2'h0;
			end
			else
			begin
				if (do_wr)
				begin
					mem_reg[wr_ptr_reg] <= push_entry_reg;
					wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
				end
				if (do_rd)
					rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
				count_reg <= count_reg + 2'(do_wr) - 2'(do_rd);
			end
		end
	end

	// Head of buffer registered so outputs come straight from flip-flops.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_data_buffer <= 8'h00;
			rx_ninth_bit <= 1'b0;
			frame_error_flag <= 1'b0;
			rx_complete_flag <= 1'b0;
			rx_count <= 2'h0;
		end
		else if (clk_en)
		begin
			rx_data_buffer <= mem_reg[rd_ptr_reg].data;
			rx_ninth_bit <= mem_reg[rd_ptr_reg].ninth;
			frame_error_flag <= mem_reg[rd_ptr_reg].frame_err;
			rx_complete_flag <= count_reg != 2'h0;
			rx_count <= count_reg;
		end
	end

	chk_flush_empties: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !cfg.receiver_enable |=> count_reg == 2'h0)
		else $error("buffer not flushed on disable");
	chk_complete_tracks: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en |=> rx_complete_flag == ($past(count_reg) != 2'h0))
		else $error("complete flag mismatch");
	chk_sample_range: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg != UARX_IDLE |-> sample_reg >= 5'h01 && sample_reg <= spb)
		else $error("sample index out of range");
	sequence uarx_edge_seen;
		clk_en && cfg.receiver_enable && tick_reg && state_reg == UARX_IDLE && fall_seen;
	endsequence
	sequence uarx_stop_vote;
		clk_en && cfg.receiver_enable && state_reg == UARX_STOP && tick_reg && sample_reg == vote_last;
	endsequence
	chk_start_begins: assert property (@(posedge clk) disable iff (!rst_n)
		uarx_edge_seen |=> state_reg == UARX_START && sample_reg == 5'h02)
		else $error("start detection not begun");
	// A low level without a preceding high sample must leave the receiver idle.
	chk_idle_waits: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && tick_reg && state_reg == UARX_IDLE && !fall_seen
		|=> state_reg == UARX_IDLE)
		else $error("start begun without a falling edge");
	chk_noise_reject: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && state_reg == UARX_START && tick_reg && sample_reg == vote_last && voted
		|=> state_reg == UARX_IDLE)
		else $error("noise start accepted");
	chk_start_resync: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && state_reg == UARX_START && bit_done
		|=> state_reg == UARX_DATA && sample_reg == 5'h01)
		else $error("bit phase not restarted after start");
	chk_frame_error: assert property (@(posedge clk) disable iff (!rst_n)
		uarx_stop_vote |=> push_entry_reg.frame_err == !$past(voted))
		else $error("frame error not stored");
	chk_ninth_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && state_reg == UARX_STOP && tick_reg && sample_reg == vote_last
		&& nbits != 4'h9 |=> !push_entry_reg.ninth)
		else $error("ninth bit kept in short frame");
	chk_filter_drop: assert property (@(posedge clk) disable iff (!rst_n)
		push_reg && cfg.multiproc_filter_enable && $stable(cfg.multiproc_filter_enable)
		|-> $past(frame_type))
		else $error("data frame passed filter");
	chk_filter_pass: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && state_reg == UARX_STOP && tick_reg && sample_reg == vote_last
		&& !cfg.multiproc_filter_enable |=> push_reg)
		else $error("unfiltered frame not pushed");
	chk_no_edge_midframe: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && state_reg == UARX_DATA && tick_reg && !bit_done
		|=> state_reg == UARX_DATA)
		else $error("frame restarted mid-bit");
	chk_stop_release: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && state_reg == UARX_STOP && stop_phase_end |=> state_reg == UARX_IDLE)
		else $error("stop phase not ended");
	// A read without a simultaneous write must take exactly one entry out.
	chk_read_pops: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && cfg.receiver_enable && do_rd && !do_wr |=> count_reg == $past(count_reg) - 2'h1)
		else $error("read did not pop the buffer");
	chk_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
		!(count_reg > 2'(DEPTH)))
		else $error("buffer count above depth");
endmodule
`default_nettype wire

// >>> inc/uarx_pkg.sv
// Package for the asynchronous receiver front end: constants, states and carriers.
// Assumes a single 200 MHz system clock domain.
package uarx_pkg;
	localparam int unsigned UARX_CLK_MHZ = 200;
	localparam logic [15:0] UARX_DIV_RESET = 16'h0000;
	localparam logic [4:0] UARX_SPB_NORMAL = 5'h10;
	localparam logic [4:0] UARX_SPB_DOUBLE = 5'h08;
	localparam logic [4:0] UARX_VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] UARX_VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [2:0] UARX_SIZE_NINE = 3'h7;
	localparam logic [2:0] UARX_SIZE_RESET = 3'h3;
	localparam int unsigned UARX_FIFO_DEPTH = 2;
	typedef enum logic [2:0]
	{
		UARX_IDLE = 3'b000,
		UARX_START = 3'b001,
		UARX_DATA = 3'b011,
		UARX_PARITY = 3'b010,
		UARX_STOP = 3'b110
	} uarx_state_t;
	typedef struct packed
	{
		logic [7:0] data;
		logic ninth;
		logic frame_err;
	} uarx_entry_t;
	typedef struct packed
	{
		logic receiver_enable;
		logic double_speed_select;
		logic multiproc_filter_enable;
		logic parity_enable;
		logic [2:0] char_size_select;
		logic [15:0] baud_divider;
	} uarx_cfg_t;
endpackage

// >>> tb/uarx_tx_model.sv
// Behavioural remote transmitter that drives the receiver's serial line.
// Assumes the caller passes the bit time in system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module uarx_tx_model
(
	input wire logic clk,
	output logic serial_line
);
	initial serial_line = 1'b1;
	// Bit time is exactly the receiver's nominal rate, well inside both tolerance windows.
	task automatic send(input logic [9:0] bits, input int n, input int bt);
		int i;
		@(posedge clk);
		serial_line <= 1'b0;
		repeat (bt) @(posedge clk);
		for (i = 0; i < n; i++)
		begin
			serial_line <= bits[i];
			repeat (bt) @(posedge clk);
		end
		serial_line <= 1'b1;
	endtask
	task automatic glitch(input int clks);
		@(posedge clk);
		serial_line <= 1'b0;
		repeat (clks) @(posedge clk);
		serial_line <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_uarx_receiver.sv
// Self-checking bench for the receiver front end, fed by a behavioural transmitter.
// Assumes a 200 MHz clock and a sample tick every second clock.
`timescale 1ns/1ps
`default_nettype none
module tb_uarx_receiver
	import uarx_pkg::*;
;
	localparam logic [15:0] DIV = 16'h0001;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd_strobe = 1'b0;
	logic clk_en = 1'b1;
	uarx_cfg_t cfg = '0;
	wire logic serial_line;
	logic [7:0] rx_data_buffer;
	logic rx_ninth_bit, frame_error_flag, rx_complete_flag;
	logic [1:0] rx_count;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int bt = 32;
	uarx_tx_model uarx_tx_model_i (.clk(clk), .serial_line(serial_line));
	uarx_receiver uarx_receiver_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .serial_rx_pin(serial_line),
		.cfg(cfg), .parity_odd(1'b0), .rd_strobe(rd_strobe), .rx_data_buffer(rx_data_buffer),
		.rx_ninth_bit(rx_ninth_bit), .frame_error_flag(frame_error_flag),
		.rx_complete_flag(rx_complete_flag), .rx_count(rx_count));
	initial forever #2.5 clk = ~clk;
	task automatic complete_run();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Outputs are read mid-cycle, away from the edge that updates them.
	task automatic head(input logic [7:0] d, input logic n9, input logic fe, input logic [1:0] cnt);
		@(negedge clk);
		chk("head", {1'b1, cnt, fe, n9, d}, {rx_complete_flag, rx_count, frame_error_flag, rx_ninth_bit, rx_data_buffer});
	endtask
	task automatic level(input logic [1:0] cnt);
		@(negedge clk);
		chk("level", {10'h0, cnt != 2'h0, cnt}, {10'h0, rx_complete_flag, rx_count});
	endtask
	task automatic pop();
		@(posedge clk);
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// Config may only change while the receiver is off, so every change passes through a disable.
	task automatic set_cfg(input logic ds, input logic mp, input logic [2:0] sz);
		@(posedge clk);
		cfg.receiver_enable <= 1'b0;
		repeat (2) @(posedge clk);
		cfg <= '{1'b0, ds, mp, 1'b0, sz, DIV};
		repeat (2) @(posedge clk);
		cfg.receiver_enable <= 1'b1;
		repeat (2) @(posedge clk);
		bt = (int'(DIV) + 1) * (ds ? int'(UARX_SPB_DOUBLE) : int'(UARX_SPB_NORMAL));
	endtask
	task automatic rx(input logic [9:0] bits, input int n);
		uarx_tx_model_i.send(bits, n, bt);
		repeat (6) @(posedge clk);
	endtask
	task automatic t_basic();
		set_cfg(1'b0, 1'b0, 3'h3);
		uarx_tx_model_i.send({2'b01, 8'ha5}, 9, bt);
		rx({2'b00, 8'h3c}, 9);
		head(8'ha5, 1'b0, 1'b0, 2'h2);
		pop();
		head(8'h3c, 1'b0, 1'b1, 2'h1);
		pop();
		level(2'h0);
	endtask
	task automatic t_spike(input logic ds, input int clks);
		set_cfg(ds, 1'b0, 3'h3);
		uarx_tx_model_i.glitch(clks);
		repeat (3 * bt) @(posedge clk);
		level(2'h0);
		rx({2'b01, 8'h81}, 9);
		head(8'h81, 1'b0, 1'b0, 2'h1);
		pop();
	endtask
	task automatic t_nine();
		set_cfg(1'b0, 1'b0, UARX_SIZE_NINE);
		rx({2'b11, 8'h96}, 10);
		rx({2'b10, 8'h69}, 10);
		head(8'h96, 1'b1, 1'b0, 2'h2);
		pop();
		head(8'h69, 1'b0, 1'b0, 2'h1);
		pop();
	endtask
	task automatic t_filter();
		set_cfg(1'b0, 1'b1, 3'h3);
		rx({2'b00, 8'h11}, 9);
		level(2'h0);
		rx({2'b01, 8'h22}, 9);
		head(8'h22, 1'b0, 1'b0, 2'h1);
		pop();
		set_cfg(1'b0, 1'b1, UARX_SIZE_NINE);
		rx({2'b10, 8'h33}, 10);
		level(2'h0);
		rx({2'b11, 8'h44}, 10);
		head(8'h44, 1'b1, 1'b0, 2'h1);
		pop();
		set_cfg(1'b0, 1'b0, UARX_SIZE_NINE);
		rx({2'b10, 8'h55}, 10);
		head(8'h55, 1'b0, 1'b0, 2'h1);
		pop();
	endtask
	task automatic t_flush();
		set_cfg(1'b0, 1'b0, 3'h3);
		rx({2'b01, 8'h01}, 9);
		rx({2'b01, 8'h02}, 9);
		rx({2'b01, 8'h03}, 9);
		head(8'h01, 1'b0, 1'b0, 2'h2);
		pop();
		head(8'h02, 1'b0, 1'b0, 2'h1);
		pop();
		level(2'h0);
		rx({2'b01, 8'h04}, 9);
		rx({2'b01, 8'h05}, 9);
		level(2'h2);
		// With the clock enable low the disable must not act yet.
		@(posedge clk);
		clk_en <= 1'b0;
		cfg.receiver_enable <= 1'b0;
		repeat (4) @(posedge clk);
		level(2'h2);
		@(posedge clk);
		clk_en <= 1'b1;
		repeat (4) @(posedge clk);
		level(2'h0);
	endtask
	// Parity bit zero before a good stop: a missed parity slot would vote the stop onto it.
	task automatic t_parity();
		set_cfg(1'b0, 1'b0, 3'h3);
		@(posedge clk);
		cfg.receiver_enable <= 1'b0;
		repeat (2) @(posedge clk);
		cfg.parity_enable <= 1'b1;
		repeat (2) @(posedge clk);
		cfg.receiver_enable <= 1'b1;
		repeat (2) @(posedge clk);
		rx({2'b10, 8'hc3}, 10);
		head(8'hc3, 1'b0, 1'b0, 2'h1);
		pop();
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		level(2'h0);
		t_basic();
		t_spike(1'b0, 6);
		t_spike(1'b1, 4);
		set_cfg(1'b1, 1'b0, 3'h3);
		rx({2'b01, 8'h5a}, 9);
		head(8'h5a, 1'b0, 1'b0, 2'h1);
		pop();
		t_nine();
		t_filter();
		t_parity();
		t_flush();
		complete_run();
	end
endmodule
`default_nettype wire
